// ### design/fdsel_pkg.sv
// Shared constants for the disk drive select link, both ends.
package fdsel_pkg;
    // Clock rate in MHz, period 4 ns
    localparam int CLK_MHZ = 250;
    // Read pulse width in ns and its cycle count
    localparam int RD_PULSE_NS = 200;
    localparam int RD_PULSE_CYC = (RD_PULSE_NS * CLK_MHZ) / 1000;
    // Controller read-start waits, plus the select-to-step wait
    localparam int MOTOR_WAIT_MS = 250;
    localparam int STEP_WAIT_MS = 20;
    localparam int WBUSY_WAIT_US = 100;
    localparam int SEL_WAIT_MS = 20;
    localparam int MOTOR_WAIT_CYC = MOTOR_WAIT_MS * CLK_MHZ * 1000;
    localparam int STEP_WAIT_CYC = STEP_WAIT_MS * CLK_MHZ * 1000;
    localparam int WBUSY_WAIT_CYC = WBUSY_WAIT_US * CLK_MHZ;
    localparam int SEL_WAIT_CYC = SEL_WAIT_MS * CLK_MHZ * 1000;
    // Number of select lines on the cable
    localparam int NUM_SEL = 4;
    // Stepper power source codes
    localparam logic [1:0] PWR_BY_HEAD_LOAD = 2'h1;
    localparam logic [1:0] PWR_BY_SELECT = 2'h2;
    // Controller register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CMD = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [3:0] REG_IRQ_STAT = 4'h3;
    localparam logic [3:0] REG_IRQ_EN = 4'h4;
    localparam logic [3:0] REG_IRQ_CLR = 4'h5;
    localparam logic [3:0] REG_RDCNT = 4'h6;
    // Control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_EN = 2;
    localparam int CTRL_MOTOR = 3;
    localparam int CTRL_HEAD_LOAD = 4;
    localparam int CTRL_WGATE = 5;
    localparam int CTRL_DIR = 6;
    localparam int CTRL_SIDE = 7;
    // Command register fields
    localparam int CMD_STEP = 0;
    // Status and event bit positions
    localparam int ST_READY = 0;
    localparam int ST_TRK0 = 1;
    localparam int ST_WPROT = 2;
    localparam int ST_CHANGE = 3;
    localparam int ST_TWO_SIDED = 4;
    localparam int ST_READ_OK = 5;
    localparam int ST_STEP_BUSY = 6;
    localparam int EV_INDEX = 0;
    localparam int EV_RDATA = 1;
    localparam int EV_CHANGE = 2;
    localparam int EV_READ_OK = 3;
    localparam int NUM_EV = 4;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] IRQ_EN_RST = 4'h0;
endpackage : fdsel_pkg

// ### design/fdsel_if.sv
// Cable between disk controller and drive; every line active low.
`timescale 1ns/100ps
interface fdsel_if;
    logic [3:0] select_line_n;
    logic head_load_n;
    logic step_n;
    logic dir_n;
    logic wgate_n;
    logic side_n;
    logic motor_off_n;
    logic read_data_n;
    logic index_n;
    logic ready_n;
    logic trk0_n;
    logic wprot_n;
    logic change_n;
    logic two_sided_n;
    // Controller end
    modport ctl (
        output select_line_n, head_load_n, step_n, dir_n, wgate_n,
        output side_n, motor_off_n,
        input read_data_n, index_n, ready_n, trk0_n, wprot_n,
        input change_n, two_sided_n
    );
    // Drive end
    modport drv (
        input select_line_n, head_load_n, step_n, dir_n, wgate_n,
        input side_n, motor_off_n,
        output read_data_n, index_n, ready_n, trk0_n, wprot_n,
        output change_n, two_sided_n
    );
endinterface : fdsel_if

// ### design/fdsel_drive.sv
// Drive end: select gating, read pulses, stepper power and head choice.
`timescale 1ns/100ps
// Function
// R1: One 200 ns read pulse per peak; peaks closer than the width merge into one longer pulse
// R2: Controller waits latest settle before reading
// R3: All cable lines active low
// R4: Respond only to configured select line
// R5: Selected drive accepts step and read/write
// R6: Deselected drive ignores inputs, outputs inactive; step_dir and head_sel still follow the dir, side and select lines
// R7: Controller asserts one select at most
// R8: Controller holds select until command done
// R9: Controller waits 20 ms before stepping
// R10: Stepper powered by head load while selected
// R11: Stepper powered by select option
// R12: Status outputs gated by own select
// R13: Head chosen by addressing select line
// R14: Ready only selected, up to speed, able
// R15: Disk change held until next deselect edge
// R16: Stepping blocked while writing
// R17: Select address latched as static configuration
module fdsel_drive
    import fdsel_pkg::*;
#(
    parameter int PULSE_CYC = RD_PULSE_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    // Cable toward the controller
    fdsel_if.drv cable,
    // Configuration straps, read as levels
    input wire logic [1:0] cfg_addr,
    input wire logic [1:0] cfg_power,
    input wire logic cfg_head_by_sel,
    input wire logic [3:0] cfg_head_map,
    // Media and mechanism sensors, active high
    input wire logic read_peak,
    input wire logic index_hole,
    input wire logic up_to_speed,
    input wire logic rw_able,
    input wire logic at_track0,
    input wire logic write_protect,
    input wire logic two_sided_disk,
    input wire logic lever_open,
    input wire logic write_busy,
    // Mechanism controls, active high
    output logic step_pulse,
    output logic step_dir,
    output logic stepper_power,
    output logic write_enable,
    output logic head_sel
);
    // ********************************************************
    // Static configuration
    // ********************************************************
    logic [1:0] addr;
    logic cfg_done;
    // Caught once after reset so a moving plug cannot re-address
    // A new address therefore takes a reset to apply
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr <= 2'h0;
            cfg_done <= 1'b0;
        end else if (!cfg_done) begin
            addr <= cfg_addr; // [R17]
            cfg_done <= 1'b1;
        end
    end

    // ********************************************************
    // Select decode
    // ********************************************************
    // Lines arrive low true; flipped once here
    wire [3:0] sel_act = ~cable.select_line_n; // [R3]
    wire selected = cfg_done & sel_act[addr]; // [R4]
    // Any line low, ours or not, for the head choice
    wire any_sel = |sel_act;
    logic [1:0] which_sel;
    // Highest active line wins; with one line low it is that one
    always_comb begin
        which_sel = 2'h0;
        for (int i = 0; i < NUM_SEL; i++) begin
            if (sel_act[i]) begin
                which_sel = 2'(i);
            end
        end
    end
    // Inputs only count while selected
    wire step_in = selected & ~cable.step_n; // [R5] [R6]
    wire wgate_in = selected & ~cable.wgate_n; // [R5] [R6]
    wire hl_in = selected & ~cable.head_load_n; // [R10]
    // Head from the strap map of the active line, else side line
    wire hsel_by_line = cfg_head_map[which_sel];
    wire next_head = (cfg_head_by_sel && any_sel) ? hsel_by_line :
        ~cable.side_n; // [R13]

    // ********************************************************
    // Read pulse shaper
    // ********************************************************
    logic [7:0] pulse_cnt;
    logic peak_d;
    // Peak edge found against the previous sample
    wire peak_rise = read_peak & ~peak_d;
    // New peak restarts the pulse; width is fixed in cycles
    // Peaks closer than the width merge into one longer pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pulse_cnt <= 8'h00;
            peak_d <= 1'b0;
        end else begin
            peak_d <= read_peak;
            if (peak_rise) begin
                pulse_cnt <= 8'(PULSE_CYC); // [R1]
            end else if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
        end
    end

    // ********************************************************
    // Disk change latch
    // ********************************************************
    logic change;
    logic sel_d;
    // Select trailing edge clears the change latch
    wire sel_fall = sel_d & ~selected;
    // Lever open wins over the clearing select trailing edge
    // A lever held open keeps the flag set across selects
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            change <= 1'b0;
            sel_d <= 1'b0;
        end else begin
            sel_d <= selected;
            if (lever_open) begin
                change <= 1'b1; // [R15]
            end else if (sel_fall) begin
                change <= 1'b0; // [R15]
            end
        end
    end

    // ********************************************************
    // Stepper and heads
    // ********************************************************
    logic step_d;
    wire step_edge = step_in & ~step_d;
    // Power source picked by strap; deselect always removes it
    wire next_power = (cfg_power == PWR_BY_SELECT) ? selected : // [R11]
        hl_in; // [R10]
    // Steps are dropped, not queued, while a write is under way
    wire step_ok = step_edge & ~write_busy & ~wgate_in; // [R16]
    // Write protect locks out the write gate
    wire next_wen = wgate_in & ~write_protect;
    // Mechanism controls come from flops so none can glitch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            step_d <= 1'b0;
            step_pulse <= 1'b0;
            step_dir <= 1'b0;
            stepper_power <= 1'b0;
            write_enable <= 1'b0;
            head_sel <= 1'b0;
        end else begin
            step_d <= step_in;
            step_pulse <= step_ok; // [R16]
            step_dir <= ~cable.dir_n;
            stepper_power <= next_power;
            write_enable <= next_wen;
            head_sel <= next_head; // [R13]
        end
    end

    // ********************************************************
    // Status gating terms
    // ********************************************************
    // Deselected, every term is false and its line rests high
    wire pulse_on = selected & (pulse_cnt != 8'h00); // [R1] [R6]
    wire index_on = selected & index_hole; // [R12]
    wire ready_on = selected & up_to_speed & rw_able; // [R14]
    wire trk0_on = selected & at_track0; // [R12]
    wire wprot_on = selected & write_protect; // [R12]
    wire change_on = selected & change; // [R12] [R15]
    wire two_on = selected & two_sided_disk; // [R6]

    // ********************************************************
    // Gated status outputs, all driven low-true from flops
    // ********************************************************
    // Outputs rest high through reset so no line looks asserted
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cable.read_data_n <= 1'b1;
            cable.index_n <= 1'b1;
            cable.ready_n <= 1'b1;
            cable.trk0_n <= 1'b1;
            cable.wprot_n <= 1'b1;
            cable.change_n <= 1'b1;
            cable.two_sided_n <= 1'b1;
        end else begin
            cable.read_data_n <= ~pulse_on; // [R1] [R3]
            cable.index_n <= ~index_on; // [R12]
            cable.ready_n <= ~ready_on; // [R14]
            cable.trk0_n <= ~trk0_on; // [R12]
            cable.wprot_n <= ~wprot_on; // [R12]
            cable.change_n <= ~change_on; // [R15]
            cable.two_sided_n <= ~two_on; // [R6]
        end
    end
endmodule : fdsel_drive

// ### design/fdsel_ctl.sv
// Controller end: Avalon-MM registers driving the drive cable.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module fdsel_ctl
    import fdsel_pkg::*;
#(
    parameter int MOTOR_CYC = MOTOR_WAIT_CYC,
    parameter int STEPW_CYC = STEP_WAIT_CYC,
    parameter int WBUSY_CYC = WBUSY_WAIT_CYC,
    parameter int SELW_CYC = SEL_WAIT_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    fdsel_if.ctl cable
);
    // ********************************************************
    // Bus decode; one wait cycle then acknowledge
    // ********************************************************
    logic ack;
    wire access = (avs_read | avs_write) & ~ack;
    wire wr = avs_write & ack;
    wire wr_ctrl = wr && (avs_address == REG_CTRL);
    wire wr_cmd = wr && (avs_address == REG_CMD);
    wire wr_en = wr && (avs_address == REG_IRQ_EN);
    wire wr_clr = wr && (avs_address == REG_IRQ_CLR);

    logic [7:0] ctrl;
    logic [NUM_EV-1:0] ev_stat;
    logic [NUM_EV-1:0] ev_en;
    logic [15:0] rd_cnt;
    logic [31:0] wait_cnt;
    logic [31:0] step_wait;
    logic [31:0] sel_wait;
    logic step_pend;
    logic wb_seen;

    // ********************************************************
    // Read-start timers
    // ********************************************************
    wire sel_chg = wr_ctrl &&
        (avs_writedata[2:0] != ctrl[2:0]);
    wire motor_start = wr_ctrl && avs_writedata[CTRL_MOTOR] &&
        !ctrl[CTRL_MOTOR];
    wire wg_end = wr_ctrl && !avs_writedata[CTRL_WGATE] &&
        ctrl[CTRL_WGATE];
    wire step_go = step_pend && (sel_wait == 32'h0) && ctrl[CTRL_SEL_EN];
    wire read_ok = (wait_cnt == 32'h0) && (step_wait == 32'h0);
    // Latest of three waits: each arming loads the max remaining
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 32'h0000_0000;
            step_wait <= 32'h0000_0000;
            sel_wait <= 32'h0000_0000;
            step_pend <= 1'b0;
        end else begin
            if (motor_start && wait_cnt < 32'(MOTOR_CYC)) begin
                wait_cnt <= 32'(MOTOR_CYC); // [R2]
            end else if (wg_end && wait_cnt < 32'(WBUSY_CYC)) begin
                wait_cnt <= 32'(WBUSY_CYC); // [R2]
            end else if (wait_cnt != 32'h0) begin
                wait_cnt <= wait_cnt - 32'h1;
            end
            if (step_go) begin
                step_wait <= 32'(STEPW_CYC); // [R2]
            end else if (step_wait != 32'h0) begin
                step_wait <= step_wait - 32'h1;
            end
            if (sel_chg) begin
                sel_wait <= 32'(SELW_CYC); // [R9]
            end else if (sel_wait != 32'h0) begin
                sel_wait <= sel_wait - 32'h1;
            end
            if (wr_cmd && avs_writedata[CMD_STEP]) begin
                step_pend <= 1'b1;
            end else if (step_go) begin
                step_pend <= 1'b0;
            end
        end
    end

    // ********************************************************
    // Registers and events
    // ********************************************************
    logic idx_d;
    logic rd_d;
    logic chg_d;
    logic ok_d;
    wire [NUM_EV-1:0] ev_set = {read_ok & ~ok_d,
        ~cable.change_n & ~chg_d, ~cable.read_data_n & ~rd_d,
        ~cable.index_n & ~idx_d};
    wire [NUM_EV-1:0] clr_mask = wr_clr ? avs_writedata[NUM_EV-1:0] :
        '0;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack <= 1'b0;
            ctrl <= CTRL_RST;
            ev_en <= IRQ_EN_RST;
            ev_stat <= '0;
            rd_cnt <= 16'h0000;
            {idx_d, rd_d, chg_d, ok_d} <= 4'h0;
        end else begin
            ack <= access;
            {idx_d, rd_d, chg_d, ok_d} <= {~cable.index_n,
                ~cable.read_data_n, ~cable.change_n, read_ok};
            if (wr_ctrl) begin
                ctrl <= avs_writedata[7:0];
            end
            if (wr_en) begin
                ev_en <= avs_writedata[NUM_EV-1:0];
            end
            // Set beats clear in the same cycle
            ev_stat <= (ev_stat & ~clr_mask) | ev_set;
            if (ev_set[EV_RDATA]) begin
                rd_cnt <= rd_cnt + 16'h0001;
            end
        end
    end

    wire [6:0] stat = {step_pend, read_ok, ~cable.two_sided_n,
        ~cable.change_n, ~cable.wprot_n, ~cable.trk0_n, ~cable.ready_n};
    logic [31:0] rdata;
    always_comb begin
        case (avs_address)
            REG_CTRL: rdata = {24'h0, ctrl};
            REG_STAT: rdata = {25'h0, stat};
            REG_IRQ_STAT: rdata = {28'h0, ev_stat};
            REG_IRQ_EN: rdata = {28'h0, ev_en};
            REG_RDCNT: rdata = {16'h0, rd_cnt};
            default: rdata = 32'h0000_0000;
        endcase
    end

    // ********************************************************
    // Cable drive, one select line at most, low true
    // ********************************************************
    logic [3:0] sel_dec;
    always_comb begin
        sel_dec = 4'h0;
        sel_dec[ctrl[1:0]] = ctrl[CTRL_SEL_EN]; // [R7]
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
            irq <= 1'b0;
            cable.select_line_n <= 4'hf;
            cable.head_load_n <= 1'b1;
            cable.step_n <= 1'b1;
            cable.dir_n <= 1'b1;
            cable.wgate_n <= 1'b1;
            cable.side_n <= 1'b1;
            cable.motor_off_n <= 1'b1;
        end else begin
            avs_readdata <= rdata;
            avs_waitrequest <= ~access;
            irq <= |(ev_stat & ev_en);
            // Select held from register until software changes it
            cable.select_line_n <= ~sel_dec; // [R3] [R8]
            cable.head_load_n <= ~ctrl[CTRL_HEAD_LOAD];
            cable.step_n <= ~step_go; // [R9]
            cable.dir_n <= ~ctrl[CTRL_DIR];
            cable.wgate_n <= ~ctrl[CTRL_WGATE];
            cable.side_n <= ~ctrl[CTRL_SIDE];
            cable.motor_off_n <= ~ctrl[CTRL_MOTOR];
        end
    end
endmodule : fdsel_ctl

// ### tb/fdsel_asserts.sv
// Cable checker for the drive select link.
`timescale 1ns/100ps
module fdsel_asserts
    import fdsel_pkg::*;
#(
    parameter int SEL_IDX = 1,
    parameter int PCYC = 50,
    parameter int SELW = 20
) (
    input logic clk,
    input logic nrst,
    input logic [3:0] select_line_n,
    input logic step_n,
    input logic wgate_n,
    input logic head_load_n,
    input logic read_data_n,
    input logic index_n,
    input logic ready_n,
    input logic trk0_n,
    input logic wprot_n,
    input logic change_n,
    input logic two_sided_n
);
    // ************
    // Helper logic
    // ************
    // A few cycles of pipeline slack between register write and cable
    localparam int SELW_MIN = SELW - 4;
    logic [7:0] low_cnt;
    logic [15:0] sel_age;
    logic [3:0] last_sel;
    wire mine_n = select_line_n[SEL_IDX];
    // Read pulse length and age of the current select pattern
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt <= 8'h00;
            sel_age <= 16'h0000;
            last_sel <= 4'hf;
        end else begin
            low_cnt <= read_data_n ? 8'h00 : low_cnt + 8'h01;
            sel_age <= (select_line_n != last_sel) ? 16'h0000 :
                sel_age + {15'h0000, ~&sel_age};
            last_sel <= select_line_n;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Own line high for two samples: outputs must have gone quiet
    sequence desel_s;
        mine_n ##1 mine_n;
    endsequence
    sequence step_s;
        !step_n && (select_line_n != 4'hf);
    endsequence
    pulse_width_a: assert property (
        $rose(read_data_n) |-> low_cnt == PCYC)
        else $error("read pulse width wrong");
    idle_high_a: assert property (
        $rose(nrst) |-> &{select_line_n, step_n, wgate_n, head_load_n})
        else $error("cable not idle after reset");
    desel_quiet_a: assert property (
        desel_s |-> &{ready_n, trk0_n, wprot_n, change_n,
        two_sided_n, index_n, read_data_n})
        else $error("deselected drive drives status");
    ready_own_a: assert property (!ready_n |-> $past(!mine_n))
        else $error("ready without own select");
    one_select_a: assert property ($onehot0(~select_line_n))
        else $error("several select lines low");
    step_held_a: assert property (step_s |=> $stable(select_line_n))
        else $error("select moved during step");
    write_held_a: assert property (
        !wgate_n && $past(!wgate_n) |-> $stable(select_line_n))
        else $error("select moved during write");
    step_wait_a: assert property (!step_n |-> sel_age >= SELW_MIN)
        else $error("step too soon after select");
    change_hold_a: assert property (
        !change_n && !mine_n |=> !change_n)
        else $error("disk change dropped while selected");
endmodule : fdsel_asserts

// ### tb/fdsel_tb_top.sv
// Self-checking bench for both ends of the drive select link.
`timescale 1ns/100ps
module fdsel_tb_top;
    import fdsel_pkg::*;
    localparam int PCYC = 12;
    localparam int SELW = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [1:0] cfg_addr = 2'h1;
    logic [1:0] cfg_power = 2'h1;
    logic cfg_head_by_sel = 1'b0;
    logic [3:0] cfg_head_map = 4'h2;
    // Peak, index, speed, able, trk0, wprot, two sided, lever, busy
    logic [8:0] din = 9'h000;
    logic step_pulse, step_dir, stepper_power, write_enable, head_sel;
    logic [31:0] rd;
    int n_errors = 0;
    int n_checks = 0;
    int n_steps = 0;
    int n_low = 0;
    always #2 clk = ~clk;
    fdsel_if cable_if ();
    fdsel_ctl #(.MOTOR_CYC(40), .STEPW_CYC(30), .WBUSY_CYC(20),
        .SELW_CYC(SELW)) fdsel_ctl_inst (.clk(clk), .nrst(nrst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .cable(cable_if));
    fdsel_drive #(.PULSE_CYC(PCYC)) fdsel_drive_inst (.clk(clk),
        .nrst(nrst), .cable(cable_if), .cfg_addr(cfg_addr),
        .cfg_power(cfg_power), .cfg_head_by_sel(cfg_head_by_sel),
        .cfg_head_map(cfg_head_map), .read_peak(din[0]),
        .index_hole(din[1]), .up_to_speed(din[2]), .rw_able(din[3]),
        .at_track0(din[4]), .write_protect(din[5]),
        .two_sided_disk(din[6]), .lever_open(din[7]),
        .write_busy(din[8]), .step_pulse(step_pulse),
        .step_dir(step_dir), .stepper_power(stepper_power),
        .write_enable(write_enable), .head_sel(head_sel));
    fdsel_asserts #(.SEL_IDX(1), .PCYC(PCYC), .SELW(SELW))
        fdsel_asserts_inst (.clk(clk), .nrst(nrst),
        .select_line_n(cable_if.select_line_n), .step_n(cable_if.step_n),
        .wgate_n(cable_if.wgate_n), .head_load_n(cable_if.head_load_n),
        .read_data_n(cable_if.read_data_n), .index_n(cable_if.index_n),
        .ready_n(cable_if.ready_n), .trk0_n(cable_if.trk0_n),
        .wprot_n(cable_if.wprot_n), .change_n(cable_if.change_n),
        .two_sided_n(cable_if.two_sided_n));
    // Count drive steps and low samples of the read line
    always @(posedge clk) begin
        if (step_pulse === 1'b1)
            n_steps++;
        if (cable_if.read_data_n === 1'b0)
            n_low++;
    end
    // ***********
    // Bench tasks
    // ***********
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One Avalon cycle; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 100);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i >= 100) begin
            n_errors++;
            results();
        end
    endtask : bus
    // Peak on the read signal, counting low samples of the read line
    task automatic peak();
        @(negedge clk);
        n_low = 0;
        @(posedge clk);
        din[0] <= 1'b1;
        repeat (PCYC + 6) @(posedge clk);
        din[0] <= 1'b0;
    endtask : peak
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        chk(cable_if.select_line_n, 4'hf);
        bus(1'b0, REG_CTRL, 32'h0);
        chk(rd, {24'h0, CTRL_RST});
        bus(1'b0, REG_IRQ_EN, 32'h0);
        chk(rd, {28'h0, IRQ_EN_RST});
        bus(1'b1, 4'hf, 32'hffff_ffff);
        bus(1'b0, 4'hf, 32'h0);
        chk(rd, 32'h0);
        // Another drive's line selected: ours stays out of it
        din <= 9'h07c;
        bus(1'b1, REG_CTRL, 32'h0000_0014);
        repeat (SELW + 4) @(posedge clk);
        bus(1'b1, REG_CMD, 32'h0000_0001);
        repeat (8) @(posedge clk);
        chk(n_steps, 0);
        chk(cable_if.ready_n, 1'b1);
        chk(stepper_power, 1'b0);
        // Own line selected, with motor, head load and step
        bus(1'b1, REG_CTRL, 32'h0000_005d);
        repeat (4) @(posedge clk);
        chk({cable_if.ready_n, cable_if.trk0_n, cable_if.wprot_n,
            cable_if.two_sided_n}, 4'h0);
        chk(stepper_power, 1'b1);
        chk(step_dir, 1'b1);
        din[1] <= 1'b1;
        repeat (3) @(posedge clk);
        chk(cable_if.index_n, 1'b0);
        din[1] <= 1'b0;
        repeat (SELW) @(posedge clk);
        bus(1'b1, REG_CMD, 32'h0000_0001);
        repeat (6) @(posedge clk);
        chk(n_steps, 1);
        bus(1'b0, REG_STAT, 32'h0);
        chk(rd[ST_READ_OK], 1'b0);
        repeat (60) @(posedge clk);
        bus(1'b0, REG_STAT, 32'h0);
        chk(rd[ST_READ_OK], 1'b1);
        din[3] <= 1'b0;
        repeat (3) @(posedge clk);
        chk(cable_if.ready_n, 1'b1);
        din[3] <= 1'b1;
        // Writing: a step now must not move the head
        bus(1'b1, REG_CTRL, 32'h0000_007d);
        // Write busy on, write protect off so the gate is not locked
        din[8:5] <= 4'ha;
        repeat (4) @(posedge clk);
        chk(write_enable, 1'b1);
        bus(1'b1, REG_CMD, 32'h0000_0001);
        repeat (6) @(posedge clk);
        chk(n_steps, 1);
        bus(1'b1, REG_CTRL, 32'h0000_005d);
        din[8] <= 1'b0;
        // Read pulses, interrupt raised, cleared, then masked
        bus(1'b1, REG_IRQ_EN, 32'h0000_0002);
        peak();
        chk(n_low, PCYC);
        chk(irq, 1'b1);
        bus(1'b1, REG_IRQ_CLR, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        bus(1'b1, REG_IRQ_EN, 32'h0);
        peak();
        chk(irq, 1'b0);
        bus(1'b0, REG_IRQ_STAT, 32'h0);
        chk(rd[EV_RDATA], 1'b1);
        bus(1'b0, REG_RDCNT, 32'h0);
        chk(rd, 32'h2);
        // Deselected: no pulse on the cable, stepper unpowered
        bus(1'b1, REG_CTRL, 32'h0000_0058);
        peak();
        chk(n_low, 0);
        chk(stepper_power, 1'b0);
        // Stepper power by select option
        cfg_power <= PWR_BY_SELECT;
        bus(1'b1, REG_CTRL, 32'h0000_000d);
        repeat (3) @(posedge clk);
        chk(stepper_power, 1'b1);
        // Lever opened: change held until the select trails
        din[7] <= 1'b1;
        repeat (3) @(posedge clk);
        din[7] <= 1'b0;
        repeat (3) @(posedge clk);
        chk(cable_if.change_n, 1'b0);
        bus(1'b1, REG_CTRL, 32'h0000_0008);
        repeat (3) @(posedge clk);
        chk(stepper_power, 1'b0);
        bus(1'b1, REG_CTRL, 32'h0000_000d);
        repeat (4) @(posedge clk);
        chk(cable_if.change_n, 1'b1);
        // Head chosen by the addressing line
        cfg_head_by_sel <= 1'b1;
        repeat (3) @(posedge clk);
        chk(head_sel, 1'b1);
        cfg_head_map <= 4'hd;
        repeat (3) @(posedge clk);
        chk(head_sel, 1'b0);
        // Address kept from reset even if the setting moves
        cfg_addr <= 2'h0;
        bus(1'b1, REG_CTRL, 32'h0000_000c);
        repeat (4) @(posedge clk);
        chk(cable_if.ready_n, 1'b1);
        results();
    end
endmodule : fdsel_tb_top
